// ===== logic/temp_limit_alert_unit.sv
// temperature result register and two-channel limit alert unit
// assumes conversion strobe, raw value, clear commands and
// non-volatile defaults come from logic on mclk; alert pins are
// open drain with an outside pull-up
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "alert_params.svh"
module temp_limit_alert_unit #(
  parameter int RAW_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // conversion results
  input wire logic conv_done,
  input wire logic [RAW_W-1:0] conv_raw,
  // global commands
  input wire logic alert_clear_a,
  input wire logic alert_clear_b,
  input wire logic soft_reset,
  // non-volatile limit defaults
  input wire logic [15:0] nv_high_a,
  input wire logic [15:0] nv_low_a,
  input wire logic [15:0] nv_high_b,
  input wire logic [15:0] nv_low_b,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // alert pins, open drain
  output logic limit_alert_out_a,
  output logic limit_alert_oe_a,
  input wire logic limit_alert_in_a,
  output logic limit_alert_out_b,
  output logic limit_alert_oe_b,
  input wire logic limit_alert_in_b,
  // interrupt
  output logic irq
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_r, rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ****************************************
  // result formatting
  // ****************************************
  alert_pkg::top_t st_r, st_nxt;
  logic signed [13:0] result;
  logic [15:0] result_lj;

  temp_saturate #(
    .RAW_W(RAW_W)
  ) u_sat (
    .raw(signed'(conv_raw)),
    .result(result)
  );

  // left-justified 16-bit form, low two bits zero
  assign result_lj = {result, 2'b00};

  // ****************************************
  // bus decode
  // ****************************************
  logic acc_wr, acc_rd, cfg_rd;
  logic [1:0] clr_wr;
  logic clr_a, clr_b;
  // side effects only in the ready cycle, where waitrequest is low
  assign acc_wr = avs_write && st_r.ack;
  assign acc_rd = avs_read && st_r.ack;
  assign cfg_rd = acc_rd && (avs_address == `OFS_CFG);
  assign clr_wr = (acc_wr && (avs_address == `OFS_CLEAR) && avs_byteenable[0])
    ? avs_writedata[1:0] : 2'b00;
  assign clr_a = alert_clear_a || clr_wr[0] || cfg_rd;
  assign clr_b = alert_clear_b || clr_wr[1] || cfg_rd;

  // ****************************************
  // alert channels
  // ****************************************
  logic al_a, ov_a, un_a, ove_a, une_a;
  logic al_b, ov_b, un_b, ove_b, une_b;
  logic conv_ok;
  // conversions during the default load are dropped
  assign conv_ok = conv_done && !st_r.init;

  limit_channel #(
    .W(14)
  ) u_ch_a (
    .clk(mclk),
    .rst_n(rst_n),
    .conv(conv_ok),
    .result(result),
    .high_lim(signed'(st_r.high_a[15:2])),
    .low_lim(signed'(st_r.low_a[15:2])),
    .mode(st_r.mode_a),
    .clr_alert(clr_a),
    .clr_flags(cfg_rd),
    .alert(al_a),
    .over_limit_flag(ov_a),
    .under_limit_flag(un_a),
    .over_evt(ove_a),
    .under_evt(une_a)
  );

  limit_channel #(
    .W(14)
  ) u_ch_b (
    .clk(mclk),
    .rst_n(rst_n),
    .conv(conv_ok),
    .result(result),
    .high_lim(signed'(st_r.high_b[15:2])),
    .low_lim(signed'(st_r.low_b[15:2])),
    .mode(st_r.mode_b),
    .clr_alert(clr_b),
    .clr_flags(cfg_rd),
    .alert(al_b),
    .over_limit_flag(ov_b),
    .under_limit_flag(un_b),
    .over_evt(ove_b),
    .under_evt(une_b)
  );

  // ****************************************
  // helpers
  // ****************************************
  // byte-lane merge for the 16-bit registers; lanes 2 and 3 are ignored
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  logic [7:0] cfg_val;
  logic [4:0] evt;
  always_comb begin
    cfg_val = 8'h00;
    cfg_val[`CFG_POL_A] = st_r.pol_a;
    cfg_val[`CFG_MODE_A] = st_r.mode_a;
    cfg_val[`CFG_OVER_A] = ov_a;
    cfg_val[`CFG_UNDER_A] = un_a;
    cfg_val[`CFG_POL_B] = st_r.pol_b;
    cfg_val[`CFG_MODE_B] = st_r.mode_b;
    cfg_val[`CFG_OVER_B] = ov_b;
    cfg_val[`CFG_UNDER_B] = un_b;
  end

  always_comb begin
    evt = 5'h00;
    evt[`IRQ_OVER_A] = ove_a;
    evt[`IRQ_UNDER_A] = une_a;
    evt[`IRQ_OVER_B] = ove_b;
    evt[`IRQ_UNDER_B] = une_b;
    evt[`IRQ_CONV] = conv_ok;
  end

  // ****************************************
  // read data select
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    // unmapped offsets read as zero
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `OFS_TEMP: rd_mux = {16'h0000, st_r.temp};
      `OFS_CFG: rd_mux = {24'h00_0000, cfg_val};
      `OFS_HIGH_A: rd_mux = {16'h0000, st_r.high_a};
      `OFS_LOW_A: rd_mux = {16'h0000, st_r.low_a};
      `OFS_HIGH_B: rd_mux = {16'h0000, st_r.high_b};
      `OFS_LOW_B: rd_mux = {16'h0000, st_r.low_b};
      `OFS_IRQ_STS: rd_mux = {27'h000_0000, st_r.irq_sts};
      `OFS_IRQ_MASK: rd_mux = {27'h000_0000, st_r.irq_mask};
      `OFS_PINS: rd_mux = {30'h0000_0000, st_r.pin_s2};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // one wait cycle, then a single ready cycle per request
    st_nxt.ack = (avs_read || avs_write) && !st_r.ack && !st_r.init;
    if ((avs_read || avs_write) && !st_r.ack) begin
      st_nxt.rdata = avs_read ? rd_mux : 32'h0000_0000;
    end
    if (st_r.init) begin
      st_nxt.high_a = nv_high_a;
      st_nxt.low_a = nv_low_a;
      st_nxt.high_b = nv_high_b;
      st_nxt.low_b = nv_low_b;
      st_nxt.init = 1'b0;
    end else if (soft_reset) begin
      st_nxt.init = 1'b1;
      st_nxt.mode_a = 1'b0;
      st_nxt.mode_b = 1'b0;
      st_nxt.pol_a = 1'b0;
      st_nxt.pol_b = 1'b0;
    end else if (acc_wr) begin
      unique case (avs_address)
        `OFS_CFG: begin
          if (avs_byteenable[0]) begin
            st_nxt.mode_a = avs_writedata[`CFG_MODE_A];
            st_nxt.mode_b = avs_writedata[`CFG_MODE_B];
            st_nxt.pol_a = avs_writedata[`CFG_POL_A];
            st_nxt.pol_b = avs_writedata[`CFG_POL_B];
          end
        end
        `OFS_HIGH_A: st_nxt.high_a = merge16(st_r.high_a, avs_writedata, avs_byteenable);
        `OFS_LOW_A: st_nxt.low_a = merge16(st_r.low_a, avs_writedata, avs_byteenable);
        `OFS_HIGH_B: st_nxt.high_b = merge16(st_r.high_b, avs_writedata, avs_byteenable);
        `OFS_LOW_B: st_nxt.low_b = merge16(st_r.low_b, avs_writedata, avs_byteenable);
        `OFS_IRQ_STS: begin
          if (avs_byteenable[0]) begin
            st_nxt.irq_sts = st_r.irq_sts & ~avs_writedata[4:0];
          end
        end
        `OFS_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            st_nxt.irq_mask = avs_writedata[4:0];
          end
        end
        default: st_nxt.init = st_r.init;
      endcase
    end
    // events win over a clearing write
    st_nxt.irq_sts = st_nxt.irq_sts | evt;
    if (conv_ok) begin
      st_nxt.temp = result_lj;
    end
    st_nxt.irq = |(st_r.irq_sts & st_r.irq_mask);
    // low drive when alert differs from polarity
    // idle channel pin sits at the inverse of its polarity bit
    st_nxt.oe_a = al_a ^ st_r.pol_a;
    st_nxt.oe_b = al_b ^ st_r.pol_b;
    // two flops on the pin readback, only the second is read
    st_nxt.pin_s1 = {limit_alert_in_b, limit_alert_in_a};
    st_nxt.pin_s2 = st_r.pin_s1;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.init <= 1'b1;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.temp <= 16'h0000;
      // limits hold the fallback code until init copies the stored defaults
      st_r.high_a <= `LIMIT_RST;
      st_r.low_a <= `LIMIT_RST;
      st_r.high_b <= `LIMIT_RST;
      st_r.low_b <= `LIMIT_RST;
      st_r.mode_a <= 1'b0;
      st_r.mode_b <= 1'b0;
      st_r.pol_a <= 1'b0;
      st_r.pol_b <= 1'b0;
      st_r.irq_sts <= 5'h00;
      st_r.irq_mask <= 5'h00;
      st_r.irq <= 1'b0;
      st_r.oe_a <= 1'b0;
      st_r.oe_b <= 1'b0;
      st_r.pin_s1 <= 2'h0;
      st_r.pin_s2 <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // wait request
  // ****************************************
  // own flop so the port needs no gate after the register;
  // high through reset, low only in the ready cycle
  logic wait_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !st_nxt.ack;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain: the output bit never drives high
  logic out_a_r, out_b_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end
  end

  assign limit_alert_out_a = out_a_r;
  assign limit_alert_out_b = out_b_r;
  assign limit_alert_oe_a = st_r.oe_a;
  assign limit_alert_oe_b = st_r.oe_b;
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = wait_r;
  assign irq = st_r.irq;

endmodule

// ===== logic/alert_params.svh
// constants for the temperature limit and alert unit
// assumes byte addressing on a 32-bit avalon-mm slave port
// How it works
// - result is a 14-bit twos complement count, 0.015625 degC each.
// - readings above the top code saturate at 1FFF, 127.984 degC.
// - each conversion end compares the result with both limits per channel.
// - two channels, each with own limits, pin and direction flags.
// - per-channel polarity picks an active-low or active-high pin.
// - per-channel mode bit, 0 at reset latched window, 1 hysteresis.
// - window mode latches over or under flag and asserts the pin.
// - window mode pin clears on channel clear command or config read.
// - window mode config read clears both direction flags.
// - hysteresis mode sets above high limit, releases only below low.
// - hysteresis mode under flag is inactive and reads zero.
// - hysteresis mode changes only at conversion end, ignores clears.
// - limits load non-volatile defaults at reset, writes apply at once.
// - with alerts idle, polarity bits 7 and 3 set pins as outputs.
`ifndef ALERT_PARAMS_SVH
`define ALERT_PARAMS_SVH
`define OFS_TEMP 6'h00
`define OFS_CFG 6'h04
`define OFS_HIGH_A 6'h08
`define OFS_LOW_A 6'h0C
`define OFS_HIGH_B 6'h10
`define OFS_LOW_B 6'h14
`define OFS_IRQ_STS 6'h18
`define OFS_IRQ_MASK 6'h1C
`define OFS_CLEAR 6'h20
`define OFS_PINS 6'h24
`define CFG_POL_A 7
`define CFG_MODE_A 6
`define CFG_OVER_A 5
`define CFG_UNDER_A 4
`define CFG_POL_B 3
`define CFG_MODE_B 2
`define CFG_OVER_B 1
`define CFG_UNDER_B 0
`define IRQ_OVER_A 0
`define IRQ_UNDER_A 1
`define IRQ_OVER_B 2
`define IRQ_UNDER_B 3
`define IRQ_CONV 4
`define LIMIT_RST 16'h0000
`define TEMP_MAX 14'h1FFF
`define TEMP_MIN 14'h2000
`endif

// ===== logic/alert_pkg.sv
// types shared by the alert unit and its channels
// assumes the constants header is included by each module
package alert_pkg;
  typedef struct packed {
    logic alert;
    logic over;
    logic under;
  } chan_t;
  typedef struct packed {
    logic init;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] temp;
    logic [15:0] high_a;
    logic [15:0] low_a;
    logic [15:0] high_b;
    logic [15:0] low_b;
    logic mode_a;
    logic mode_b;
    logic pol_a;
    logic pol_b;
    logic [4:0] irq_sts;
    logic [4:0] irq_mask;
    logic irq;
    logic oe_a;
    logic oe_b;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
  } top_t;
endpackage

// ===== logic/temp_saturate.sv
// clamps a wide signed conversion value to the 14-bit result range
// assumes the raw value uses the same count weight as the result
`timescale 1ns/10ps
`include "alert_params.svh"
module temp_saturate #(
  parameter int RAW_W = 16
) (
  // raw converter value
  input wire logic signed [RAW_W-1:0] raw,
  // saturated result
  output logic signed [13:0] result
);
  localparam logic signed [RAW_W-1:0] HI = RAW_W'(signed'(`TEMP_MAX));
  localparam logic signed [RAW_W-1:0] LO = RAW_W'(signed'(`TEMP_MIN));
  always_comb begin
    if (raw > HI) begin
      result = `TEMP_MAX;
    end else if (raw < LO) begin
      result = `TEMP_MIN;
    end else begin
      result = raw[13:0];
    end
  end
endmodule

// ===== logic/limit_channel.sv
// one alert channel: window or hysteresis comparator with flags
// assumes conv is a one-cycle strobe on the same clock as the result
`timescale 1ns/10ps
`include "alert_params.svh"
module limit_channel #(
  parameter int W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // conversion
  input wire logic conv,
  input wire logic signed [W-1:0] result,
  input wire logic signed [W-1:0] high_lim,
  input wire logic signed [W-1:0] low_lim,
  // control
  input wire logic mode,
  input wire logic clr_alert,
  input wire logic clr_flags,
  // state and events
  output logic alert,
  output logic over_limit_flag,
  output logic under_limit_flag,
  output logic over_evt,
  output logic under_evt
);
  alert_pkg::chan_t st_r, st_nxt;
  logic hi, lo;
  assign hi = result > high_lim;
  assign lo = result < low_lim;
  assign alert = st_r.alert;
  assign over_limit_flag = st_r.over;
  assign under_limit_flag = st_r.under;
  assign over_evt = conv && hi;
  assign under_evt = conv && lo && !mode;
  always_comb begin
    st_nxt = st_r;
    if (mode) begin
      // set above high, release below low
      if (conv && hi) begin
        st_nxt.over = 1'b1;
        st_nxt.alert = 1'b1;
      end else if (conv && lo) begin
        st_nxt.over = 1'b0;
        st_nxt.alert = 1'b0;
      end
      st_nxt.under = 1'b0;
    end else begin
      if (clr_alert) begin
        st_nxt.alert = 1'b0;
      end
      if (clr_flags) begin
        st_nxt.over = 1'b0;
        st_nxt.under = 1'b0;
      end
      if (conv && hi) begin
        st_nxt.over = 1'b1;
        st_nxt.alert = 1'b1;
      end
      if (conv && lo) begin
        st_nxt.under = 1'b1;
        st_nxt.alert = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== tb/alert_line_model.sv
// open-drain alert lines with pull-ups, seen by the monitoring logic
// assumes oe high means the unit drives its out level onto the line
`timescale 1ns/10ps
module alert_line_model (
  // unit drive
  input wire logic drv_a,
  input wire logic oe_a,
  input wire logic drv_b,
  input wire logic oe_b,
  // line levels
  output logic pin_a,
  output logic pin_b
);
  // a released line rises to the pull-up level
  assign pin_a = oe_a ? drv_a : 1'h1;
  assign pin_b = oe_b ? drv_b : 1'h1;
endmodule

// ===== tb/alert_unit_assertions.sv
// port-level assertions for the limit alert unit
// assumes binding to the unit's top module
`timescale 1ns/10ps
`include "alert_params.svh"
module alert_unit_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // events
  input wire logic conv_done,
  input wire logic alert_clear_a,
  input wire logic soft_reset,
  // bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic limit_alert_out_a,
  input wire logic limit_alert_out_b,
  input wire logic limit_alert_oe_a
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic cfg_rd;
  logic tmp_rd;
  assign cfg_rd = !avs_waitrequest && avs_read && avs_address == `OFS_CFG;
  assign tmp_rd = !avs_waitrequest && avs_read && avs_address == `OFS_TEMP;
  // ****************
  // properties
  // ****************
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("ready held long");
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("ready unasked");
  property p_answer;
    $rose(avs_read || avs_write) |-> ##[1:20] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_temp_fmt;
    tmp_rd |-> avs_readdata[31:16] == 16'h0 && avs_readdata[1:0] == 2'h0;
  endproperty
  a_temp_fmt: assert property (p_temp_fmt) else $error("bad result format");
  property p_under_a;
    cfg_rd && avs_readdata[`CFG_MODE_A] |-> !avs_readdata[`CFG_UNDER_A];
  endproperty
  a_under_a: assert property (p_under_a) else $error("under flag a set");
  property p_under_b;
    cfg_rd && avs_readdata[`CFG_MODE_B] |-> !avs_readdata[`CFG_UNDER_B];
  endproperty
  a_under_b: assert property (p_under_b) else $error("under flag b set");
  property p_cfg_release;
    cfg_rd && !avs_readdata[`CFG_MODE_A] && !conv_done |=>
      ##1 limit_alert_oe_a == $past(avs_readdata[`CFG_POL_A], 2);
  endproperty
  a_cfg_release: assert property (p_cfg_release) else $error("pin a kept");
  property p_oe_cause;
    $changed(limit_alert_oe_a) |-> $past(conv_done, 2) || $past(alert_clear_a, 2) ||
      $past(!avs_waitrequest, 2) || $past(soft_reset, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin a moved");
  property p_out_low;
    limit_alert_out_a == 1'h0 && limit_alert_out_b == 1'h0;
  endproperty
  a_out_low: assert property (p_out_low) else $error("pin driven high");
endmodule

// ===== tb/temp_limit_alert_unit_tb.sv
// bench for the limit alert unit, driven over its register bus
// assumes the pull-up line model and the port checker
`timescale 1ns/10ps
`include "alert_params.svh"
module temp_limit_alert_unit_tb;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic conv_done = 1'h0;
  logic [15:0] conv_raw = 16'h0;
  logic alert_clear_a = 1'h0;
  logic alert_clear_b = 1'h0;
  logic soft_reset = 1'h0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, out_a, oe_a, out_b, oe_b, pin_a, pin_b, irq;
  int errors = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  temp_limit_alert_unit #(.RAW_W(16)) dut (
    .mclk(mclk), .arst_n(arst_n), .conv_done(conv_done), .conv_raw(conv_raw),
    .alert_clear_a(alert_clear_a), .alert_clear_b(alert_clear_b), .soft_reset(soft_reset),
    .nv_high_a(16'h3200), .nv_low_a(16'hE700), .nv_high_b(16'h3200), .nv_low_b(16'hFF00),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .limit_alert_out_a(out_a), .limit_alert_oe_a(oe_a),
    .limit_alert_in_a(pin_a), .limit_alert_out_b(out_b), .limit_alert_oe_b(oe_b),
    .limit_alert_in_b(pin_b), .irq(irq));
  alert_line_model lines (.drv_a(out_a), .oe_a(oe_a), .drv_b(out_b), .oe_b(oe_b),
    .pin_a(pin_a), .pin_b(pin_b));
  // ****************
  // tasks
  // ****************
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 100) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic conv(input logic [15:0] r);
    @(posedge mclk);
    conv_done <= 1'h1;
    conv_raw <= r;
    @(posedge mclk);
    conv_done <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic cmd(input logic [2:0] k);
    @(posedge mclk);
    {soft_reset, alert_clear_b, alert_clear_a} <= k;
    @(posedge mclk);
    {soft_reset, alert_clear_b, alert_clear_a} <= 3'h0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic pins(input logic [1:0] e);
    repeat (2) @(posedge mclk);
    chk({30'h0, pin_b, pin_a}, {30'h0, e});
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'h1;
    rdc(`OFS_HIGH_A, 32'h3200);
    rdc(`OFS_LOW_A, 32'hE700);
    rdc(`OFS_HIGH_B, 32'h3200);
    rdc(`OFS_LOW_B, 32'hFF00);
    bus(1'h1, 6'h3C, 32'hFF);
    rdc(6'h3C, 32'h0);
    bus(1'h1, `OFS_IRQ_MASK, 32'h10);
    conv(16'h0C80);
    rdc(`OFS_TEMP, 32'h3200);
    rdc(`OFS_CFG, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, `OFS_IRQ_STS, 32'h1F);
    bus(1'h1, `OFS_HIGH_B, 32'h3204);
    chk({31'h0, irq}, 32'h0);
    rdc(`OFS_HIGH_B, 32'h3204);
    conv(16'h0C81);
    pins(2'h2);
    rdc(`OFS_PINS, 32'h2);
    rdc(`OFS_CFG, 32'h20);
    pins(2'h3);
    rdc(`OFS_CFG, 32'h0);
    conv(16'hF800);
    rdc(`OFS_TEMP, 32'hE000);
    cmd(3'h1);
    pins(2'h1);
    cmd(3'h2);
    rdc(`OFS_CFG, 32'h11);
    conv(16'h3000);
    rdc(`OFS_TEMP, 32'h7FFC);
    rdc(`OFS_CFG, 32'h22);
    bus(1'h1, `OFS_CFG, 32'h44);
    conv(16'h0D00);
    rdc(`OFS_CFG, 32'h66);
    cmd(3'h3);
    rdc(`OFS_CFG, 32'h66);
    pins(2'h0);
    conv(16'h0000);
    rdc(`OFS_CFG, 32'h66);
    conv(16'hF800);
    rdc(`OFS_CFG, 32'h44);
    pins(2'h3);
    bus(1'h1, `OFS_IRQ_MASK, 32'h0);
    bus(1'h1, `OFS_IRQ_STS, 32'h1F);
    conv(16'h0000);
    rdc(`OFS_IRQ_STS, 32'h10);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, `OFS_HIGH_A, 32'h7FFC);
    bus(1'h1, `OFS_LOW_A, 32'h8000);
    bus(1'h1, `OFS_CFG, 32'h80);
    conv(16'h3000);
    pins(2'h0);
    rdc(`OFS_CFG, 32'h82);
    pins(2'h2);
    bus(1'h1, `OFS_CFG, 32'h0);
    pins(2'h3);
    conv(16'hC000);
    avs_byteenable <= 4'h3;
    rdc(`OFS_TEMP, 32'h8000);
    avs_byteenable <= 4'hF;
    pins(2'h1);
    bus(1'h1, `OFS_CLEAR, 32'h2);
    pins(2'h3);
    rdc(`OFS_CFG, 32'h01);
    avs_byteenable <= 4'h1;
    bus(1'h1, `OFS_HIGH_B, 32'hFFFF);
    avs_byteenable <= 4'hF;
    rdc(`OFS_HIGH_B, 32'h32FF);
    cmd(3'h4);
    rdc(`OFS_HIGH_A, 32'h3200);
    rdc(`OFS_HIGH_B, 32'h3200);
    wrap_up();
  end
endmodule
bind temp_limit_alert_unit alert_unit_assertions u_chk (.mclk(mclk), .arst_n(arst_n),
  .conv_done(conv_done), .alert_clear_a(alert_clear_a), .soft_reset(soft_reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .limit_alert_out_a(limit_alert_out_a), .limit_alert_out_b(limit_alert_out_b),
  .limit_alert_oe_a(limit_alert_oe_a));
